/* File: ccl_pkg.sv */
// Purpose: shared constants and types for the condition code logic
// Assumes: one clock, synchronous active-high reset
// Notes: flag order in every nibble is n, z, v, c from bit 3 down to bit 0
package ccl_pkg;

  // operand-size codes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h3;

  // flag control field
  localparam logic [1:0] FC_NOP = 2'h0;
  localparam logic [1:0] FC_LONG = 2'h1;
  localparam logic [1:0] FC_SIZE = 2'h2;
  localparam logic [1:0] FC_COPY = 2'h3;

  // flag load select
  localparam logic [1:0] LS_BYTE = 2'h0;
  localparam logic [1:0] LS_WORD = 2'h1;
  localparam logic [1:0] LS_LONG = 2'h2;
  localparam logic [1:0] LS_HOLD = 2'h3;

  // flag class codes
  localparam logic [1:0] CLS_ADD = 2'h0;
  localparam logic [1:0] CLS_SUB = 2'h1;
  localparam logic [1:0] CLS_CMP = 2'h2;
  localparam logic [1:0] CLS_LOG = 2'h3;

  // discrete register addresses
  localparam logic [7:0] ADR_RES_FLAGS_W = 8'hfd;
  localparam logic [7:0] ADR_RES_FLAGS = 8'hfe;
  localparam logic [7:0] ADR_STAT_FLAGS = 8'h7f;
  localparam logic [7:0] ADR_STAT_FLAGS_HI = 8'hff;

  // sign bit positions and flag reset value
  localparam int SIGN_BYTE = 7;
  localparam int SIGN_WORD = 15;
  localparam int SIGN_LONG = 31;
  localparam logic [3:0] FLAGS_RST = 4'h0;

  // microinstruction kinds
  typedef enum logic [2:0] {
    UOP_GENERAL,
    UOP_TRANSFER,
    UOP_LONG_FORM,
    UOP_MEM_REQ,
    UOP_DECODE,
    UOP_JUMP,
    UOP_MISC,
    UOP_PORT
  } ccl_uop_type;

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } ccl_flags_type;

  // alu indicators per slice
  typedef struct packed {
    logic [31:0] result;
    logic ovf_7;
    logic ovf_15;
    logic ovf_31;
    logic carry_8;
    logic carry_16;
    logic carry_32;
  } ccl_alu_ind_type;

endpackage

/* File: ccl_condition_code_logic.sv */
// Purpose: result flags and status flags with load, copy and discrete access
// Assumes: all inputs come from logic on ref_clk_i; one microcycle per clock
// Notes: discrete reads are combinational muxes onto the d bus
`timescale 1ns/1ps
module ccl_condition_code_logic
  import ccl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // microinstruction control
  input wire ccl_uop_type uop_kind_i,
  input wire logic [1:0] flag_field_i,
  input wire logic [7:0] disc_addr_i,
  input wire logic disc_write_i,
  input wire logic [1:0] size_reg_i,
  input wire logic legacy_mode_i,
  input wire logic class_decode_i,
  input wire logic [1:0] class_in_i,
  // alu indicators and result bus
  input wire ccl_alu_ind_type alu_ind_i,
  input wire logic [3:0] result_bus_i,
  // outputs
  output ccl_flags_type res_flags_o,
  output logic status_carry_skip_o,
  output logic [3:0] dbus_o,
  output logic dbus_en_o,
  output logic [1:0] op_size_o
);

  ccl_flags_type res_flags_ff;
  ccl_flags_type stat_flags_ff;
  logic [1:0] flag_class_code_ff;
  logic general_op;
  logic transfer_op;
  logic [1:0] nxt_size;
  logic [1:0] flag_load_sel;
  logic status_flag_copy_strobe;
  logic result_flag_write_en;
  logic status_flag_write_en;
  ccl_flags_type ind_flags;
  ccl_flags_type copy_flags;
  logic z_byte;
  logic z_word;
  logic z_long;

  ////////////////////////////////////////////////////////////////////////////
  // decode of the microinstruction
  // only these three kinds may touch any flag
  assign general_op = (uop_kind_i == UOP_GENERAL) || (uop_kind_i == UOP_TRANSFER) ||
                      (uop_kind_i == UOP_LONG_FORM);
  assign transfer_op = (uop_kind_i == UOP_TRANSFER);

  // operand-size code from the size register, or longword for the nop and long fields; longword forced to word in legacy mode
  always_comb begin
    nxt_size = size_reg_i;
    if (flag_field_i == FC_NOP || flag_field_i == FC_LONG) begin
      nxt_size = SIZE_LONG;
    end
    if (legacy_mode_i && nxt_size == SIZE_LONG) begin
      nxt_size = SIZE_WORD;
    end
  end
  assign op_size_o = nxt_size;

  // load select and copy strobe from the flag field
  always_comb begin
    flag_load_sel = LS_HOLD;
    status_flag_copy_strobe = 1'b0;
    if (general_op) begin
      unique case (flag_field_i)
        FC_NOP: flag_load_sel = LS_HOLD;
        FC_LONG: flag_load_sel = LS_LONG;
        FC_SIZE: begin
          // size code 10 is unused; treated as longword to stay defined
          unique case (nxt_size)
            SIZE_BYTE: flag_load_sel = LS_BYTE;
            SIZE_WORD: flag_load_sel = LS_WORD;
            default: flag_load_sel = LS_LONG;
          endcase
        end
        FC_COPY: begin
          flag_load_sel = LS_HOLD;
          status_flag_copy_strobe = 1'b1;
        end
      endcase
    end
  end

  // discrete register write enables
  assign result_flag_write_en = transfer_op && disc_write_i &&
    (disc_addr_i == ADR_RES_FLAGS_W || disc_addr_i == ADR_RES_FLAGS);
  assign status_flag_write_en = (uop_kind_i == UOP_GENERAL || transfer_op) &&
    disc_write_i &&
    (disc_addr_i == ADR_STAT_FLAGS || disc_addr_i == ADR_STAT_FLAGS_HI);

  ////////////////////////////////////////////////////////////////////////////
  // indicator selection
  assign z_byte = (alu_ind_i.result[7:0] == 8'h00);
  assign z_word = (alu_ind_i.result[15:8] == 8'h00);
  assign z_long = (alu_ind_i.result[31:16] == 16'h0000);

  always_comb begin
    ind_flags.n = alu_ind_i.result[SIGN_LONG];
    ind_flags.z = z_long & z_word & z_byte;
    ind_flags.v = alu_ind_i.ovf_31;
    ind_flags.c = alu_ind_i.carry_32;
    unique case (flag_load_sel)
      LS_BYTE: begin
        ind_flags.n = alu_ind_i.result[SIGN_BYTE];
        ind_flags.z = z_byte;
        ind_flags.v = alu_ind_i.ovf_7;
        ind_flags.c = alu_ind_i.carry_8;
      end
      LS_WORD: begin
        ind_flags.n = alu_ind_i.result[SIGN_WORD];
        ind_flags.z = z_word & z_byte;
        ind_flags.v = alu_ind_i.ovf_15;
        ind_flags.c = alu_ind_i.carry_16;
      end
      LS_LONG, LS_HOLD: begin
        // longword indicators already stand from the defaults above
      end
    endcase
  end

  // class mapping of result flags onto status flags
  always_comb begin
    copy_flags = res_flags_ff;
    unique case (flag_class_code_ff)
      CLS_ADD: copy_flags = res_flags_ff;
      CLS_SUB: copy_flags.c = ~res_flags_ff.c;
      CLS_CMP: begin
        copy_flags.n = res_flags_ff.n ^ res_flags_ff.v;
        copy_flags.v = 1'b0;
        copy_flags.c = ~res_flags_ff.c;
      end
      CLS_LOG: begin
        copy_flags.v = 1'b0;
        copy_flags.c = stat_flags_ff.c;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag class register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flag_class_code_ff <= 2'h0;
    end else if (uop_kind_i == UOP_DECODE && class_decode_i) begin
      flag_class_code_ff <= class_in_i;
    end
  end

  // result flags; explicit write wins over indicator load
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      res_flags_ff <= FLAGS_RST;
    end else if (result_flag_write_en) begin
      res_flags_ff <= result_bus_i;
    end else if (flag_load_sel != LS_HOLD) begin
      res_flags_ff <= ind_flags;
    end
  end

  // status flags
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      stat_flags_ff <= FLAGS_RST;
    end else if (status_flag_write_en) begin
      stat_flags_ff <= result_bus_i;
    end else if (status_flag_copy_strobe) begin
      stat_flags_ff <= copy_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // skip conditions and d bus reads
  assign res_flags_o = res_flags_ff;
  assign status_carry_skip_o = stat_flags_ff.c;

  always_comb begin
    dbus_o = 4'h0;
    dbus_en_o = 1'b0;
    if (transfer_op && disc_addr_i == ADR_RES_FLAGS) begin
      dbus_o = res_flags_ff;
      dbus_en_o = 1'b1;
    end else if ((uop_kind_i == UOP_GENERAL || transfer_op) &&
                 (disc_addr_i == ADR_STAT_FLAGS || disc_addr_i == ADR_STAT_FLAGS_HI)) begin
      dbus_o = stat_flags_ff;
      dbus_en_o = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // a copy cycle with no explicit status write beside it
  sequence copy_go_s;
    status_flag_copy_strobe && !status_flag_write_en;
  endsequence

  // an indicator load with no explicit result write beside it
  sequence ind_go_s;
    (flag_load_sel != LS_HOLD) && !result_flag_write_en;
  endsequence

  // a size-field load of the result flags with no explicit write beside it
  sequence size_go_s;
    general_op && flag_field_i == FC_SIZE && !result_flag_write_en;
  endsequence

  // decode moves only the class register, never a flag
  hold_other_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !general_op |=> $stable(res_flags_ff) && $stable(stat_flags_ff))
    else $error("flags changed on a non-flag microinstruction");

  // an indicator load only ever comes from a flag microinstruction
  ind_load_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ind_go_s |-> general_op)
    else $error("indicator load outside a flag microinstruction");

  // nop field without a discrete write leaves both sets alone
  nop_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (general_op && flag_field_i == FC_NOP && !disc_write_i) |=>
    $stable(res_flags_ff) && $stable(stat_flags_ff))
    else $error("nop field altered flags");

  // byte size takes the low slice indicators
  byte_load_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    size_go_s ##0 (size_reg_i == SIZE_BYTE) |=>
    res_flags_ff == {$past(alu_ind_i.result[7]), $past(alu_ind_i.result[7:0] == 8'h00),
                     $past(alu_ind_i.ovf_7), $past(alu_ind_i.carry_8)})
    else $error("byte indicator load wrong");

  // word size ands two zero segments and takes the middle slice
  word_load_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    size_go_s ##0 (size_reg_i == SIZE_WORD) |=>
    res_flags_ff == {$past(alu_ind_i.result[15]), $past(alu_ind_i.result[15:0] == 16'h0000),
                     $past(alu_ind_i.ovf_15), $past(alu_ind_i.carry_16)})
    else $error("word indicator load wrong");

  // longword size outside legacy mode takes the top slice
  size_long_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    size_go_s ##0 (size_reg_i == SIZE_LONG && !legacy_mode_i) |=>
    res_flags_ff == {$past(alu_ind_i.result[31]), $past(alu_ind_i.result == 32'h00000000),
                     $past(alu_ind_i.ovf_31), $past(alu_ind_i.carry_32)})
    else $error("longword size load wrong");

  // legacy mode turns a longword size load into a word load
  legacy_load_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    size_go_s ##0 (size_reg_i == SIZE_LONG && legacy_mode_i) |=>
    res_flags_ff.c == $past(alu_ind_i.carry_16) && res_flags_ff.v == $past(alu_ind_i.ovf_15))
    else $error("legacy longword did not load word indicators");

  // long field ignores the size register
  long_load_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (general_op && flag_field_i == FC_LONG && !result_flag_write_en) |=>
    res_flags_ff.c == $past(alu_ind_i.carry_32) &&
    res_flags_ff.z == ($past(alu_ind_i.result) == 32'h00000000))
    else $error("longword indicator load wrong");

  // the size code seen outside the block follows legacy mode too
  legacy_word_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (legacy_mode_i && flag_field_i == FC_SIZE && size_reg_i == SIZE_LONG) |->
    op_size_o == SIZE_WORD)
    else $error("legacy mode did not force word");

  // byte and word codes pass straight through
  size_code_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (flag_field_i == FC_SIZE && (size_reg_i == SIZE_BYTE || size_reg_i == SIZE_WORD)) |->
    op_size_o == size_reg_i)
    else $error("operand size code wrong");

  // class register loads only on a class decode
  class_load_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (uop_kind_i == UOP_DECODE && class_decode_i) |=> flag_class_code_ff == $past(class_in_i))
    else $error("flag class not loaded");
  class_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !(uop_kind_i == UOP_DECODE && class_decode_i) |=> $stable(flag_class_code_ff))
    else $error("flag class moved without a decode");

  // add class is a straight copy
  add_copy_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    copy_go_s ##0 (flag_class_code_ff == CLS_ADD) |=> stat_flags_ff == $past(res_flags_ff))
    else $error("add class copy wrong");

  // subtract class inverts only the carry
  sub_copy_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    copy_go_s ##0 (flag_class_code_ff == CLS_SUB) |=>
    stat_flags_ff == {$past(res_flags_ff.n), $past(res_flags_ff.z),
                      $past(res_flags_ff.v), !$past(res_flags_ff.c)})
    else $error("subtract class copy wrong");

  // compare class folds overflow into negative
  cmp_copy_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    copy_go_s ##0 (flag_class_code_ff == CLS_CMP) |=>
    stat_flags_ff.v == 1'b0 && stat_flags_ff.c == !$past(res_flags_ff.c) &&
    stat_flags_ff.n == ($past(res_flags_ff.n) ^ $past(res_flags_ff.v)))
    else $error("compare class copy wrong");

  // logical class keeps the old status carry
  log_copy_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    copy_go_s ##0 (flag_class_code_ff == CLS_LOG) |=>
    $stable(stat_flags_ff.c) && stat_flags_ff.v == 1'b0)
    else $error("logical class copy wrong");

  // copying never disturbs the result flags
  copy_hold_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (status_flag_copy_strobe && !result_flag_write_en) |=> $stable(res_flags_ff))
    else $error("result flags moved during copy");

  // explicit writes win over any load in the same microcycle
  write_wins_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    result_flag_write_en |=> res_flags_ff == $past(result_bus_i))
    else $error("explicit result flag write lost");
  stat_write_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    status_flag_write_en |=> stat_flags_ff == $past(result_bus_i))
    else $error("explicit status flag write lost");

  // a transfer read of fe drives the result flags onto the d bus
  res_read_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (transfer_op && disc_addr_i == ADR_RES_FLAGS) |-> dbus_en_o && dbus_o == res_flags_ff)
    else $error("result flag read wrong");

  // reset clears both flag sets by the next edge
  rst_clear_a: assert property (@(posedge ref_clk_i)
    rst_i |=> res_flags_ff == FLAGS_RST && stat_flags_ff == FLAGS_RST)
    else $error("reset left a flag set");

endmodule

/* File: ccl_alu_model.sv */
// Purpose: behavioural bit-slice adder that feeds the flag indicators
// Assumes: add only; the indicators follow the operands combinationally
// Notes: overflow per slice is the carry into the sign bit xor the carry out of it
`timescale 1ns/1ps
module ccl_alu_model
  import ccl_pkg::*;
(
  // operands
  input wire logic [31:0] a_i,
  input wire logic [31:0] b_i,
  // indicators
  output ccl_alu_ind_type ind_o
);
  logic [32:0] sum;
  logic [32:0] cin;

  ////////////////////////////////////////////////////////////////////////////////
  // one wide add; the carry into each bit falls out of a xor b xor sum
  assign sum = {1'b0, a_i} + {1'b0, b_i};
  assign cin = {1'b0, a_i} ^ {1'b0, b_i} ^ sum;
  assign ind_o.result = sum[31:0];
  assign ind_o.ovf_7 = cin[7] ^ cin[8];
  assign ind_o.ovf_15 = cin[15] ^ cin[16];
  assign ind_o.ovf_31 = cin[31] ^ cin[32];
  assign ind_o.carry_8 = cin[8];
  assign ind_o.carry_16 = cin[16];
  assign ind_o.carry_32 = cin[32];
endmodule

/* File: tb_top.sv */
// Purpose: directed sequences of microcycles against the condition code logic
// Assumes: inputs change on the falling edge, flags are sampled after the rise
// Notes: status flags are only visible through discrete reads and the carry skip
`timescale 1ns/1ps
module tb_top;
  import ccl_pkg::*;
  logic ref_clk_i, rst_i, wr, legacy, cls_dec, lg_s, cd_s, skip, den;
  ccl_uop_type uop;
  logic [1:0] field, size, cls, sz_s, cl_s, osz;
  logic [7:0] addr;
  logic [3:0] rbus, rd, dbus, e;
  logic [31:0] opa, opb, a_s, b_s;
  ccl_alu_ind_type ind;
  ccl_flags_type res;
  int bad_count, comparisons, cycles;
  logic [31:0] av [4] = '{32'h0000007f, 32'hffffffff, 32'h00007fff, 32'h80008080};
  logic [31:0] bv [4] = '{32'h00000001, 32'h00000001, 32'h00000001, 32'h80008080};
  logic [1:0] szv [4] = '{SIZE_BYTE, SIZE_WORD, SIZE_LONG, SIZE_LONG};
  logic [1:0] osv [4] = '{SIZE_BYTE, SIZE_WORD, SIZE_LONG, SIZE_WORD};
  int wv [4] = '{8, 16, 32, 16};
  logic [3:0] cexp [4] = '{4'ha, 4'hb, 4'h1, 4'h9};

  ccl_alu_model u_ccl_alu_model (.a_i(opa), .b_i(opb), .ind_o(ind));
  ccl_condition_code_logic u_ccl_condition_code_logic (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .uop_kind_i(uop), .flag_field_i(field),
    .disc_addr_i(addr), .disc_write_i(wr), .size_reg_i(size), .legacy_mode_i(legacy),
    .class_decode_i(cls_dec), .class_in_i(cls), .alu_ind_i(ind), .result_bus_i(rbus),
    .res_flags_o(res), .status_carry_skip_o(skip), .dbus_o(dbus), .dbus_en_o(den),
    .op_size_o(osz));

  ////////////////////////////////////////////////////////////////////////////////
  // clock, and a cycle ceiling so a hang still reaches the verdict
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // expected indicators worked out from the operands, not from the model
  function automatic logic [3:0] ind_exp(logic [31:0] a, logic [31:0] b, int w);
    logic [32:0] m;
    logic [32:0] s;
    m = (33'h1 << w) - 33'h1;
    s = ({1'b0, a} & m) + ({1'b0, b} & m);
    return {s[w-1], (s & m) == 33'h0, a[w-1] == b[w-1] && s[w-1] != a[w-1], s[w]};
  endfunction

  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one microcycle; shadow values land on the falling edge with the rest
  task automatic cyc(input ccl_uop_type u, input logic [1:0] f, input logic [7:0] ad,
                     input logic w, input logic [3:0] rb);
    @(negedge ref_clk_i);
    uop = u;
    field = f;
    addr = ad;
    wr = w;
    rbus = rb;
    size = sz_s;
    legacy = lg_s;
    cls = cl_s;
    cls_dec = cd_s;
    opa = a_s;
    opb = b_s;
    @(posedge ref_clk_i);
    #1;
  endtask

  // discrete read: the d bus is combinational, so sample mid cycle
  task automatic rd_reg(input ccl_uop_type u, input logic [7:0] ad);
    @(negedge ref_clk_i);
    uop = u;
    addr = ad;
    wr = 1'b0;
    field = FC_NOP;
    cls_dec = 1'b0;
    #5 rd = dbus;
  endtask

  task automatic conclude();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst_i, wr, legacy, cls_dec, lg_s, cd_s} = 6'h20;
    {field, size, cls, sz_s, cl_s, addr, rbus, opa, opb, a_s, b_s} = '0;
    uop = UOP_MISC;
    repeat (10) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_i = 1'b0;
    check("res_rst", res, 4'h0);
    rd_reg(UOP_GENERAL, ADR_STAT_FLAGS);
    check("stat_rst", rd, 4'h0);
    // every operand pair at byte, word, long and long under legacy mode
    for (int p = 0; p < 4; p++) begin
      for (int s = 0; s < 4; s++) begin
        a_s = av[p];
        b_s = bv[p];
        sz_s = szv[s];
        lg_s = (s == 3);
        cyc(UOP_GENERAL, FC_SIZE, 8'h00, 1'b0, 4'h0);
        check("op_size", {2'h0, osz}, {2'h0, osv[s]});
        check("res_size", res, ind_exp(av[p], bv[p], wv[s]));
      end
    end
    sz_s = SIZE_BYTE;
    lg_s = 1'b0;
    cyc(UOP_LONG_FORM, FC_LONG, 8'h00, 1'b0, 4'h0);
    check("res_long", res, ind_exp(a_s, b_s, 32));
    e = res;
    a_s = 32'h0;
    b_s = 32'h0;
    cyc(UOP_GENERAL, FC_NOP, 8'h00, 1'b0, 4'h0);
    check("res_nop", res, e);
    for (int u = 3; u < 8; u++) begin
      cyc(ccl_uop_type'(u[2:0]), FC_SIZE, 8'h00, 1'b0, 4'h0);
      check("res_other", res, e);
    end
    // explicit write and indicator load in the same cycle
    cyc(UOP_TRANSFER, FC_SIZE, ADR_RES_FLAGS_W, 1'b1, 4'h6);
    check("res_wr", res, 4'h6);
    rd_reg(UOP_TRANSFER, ADR_RES_FLAGS);
    check("res_rd", rd, 4'h6);
    check("rd_en", {3'h0, den}, 4'h1);
    // each flag class: load class, preset both sets, copy, read back
    for (int k = 0; k < 4; k++) begin
      cl_s = k[1:0];
      cd_s = 1'b1;
      cyc(UOP_DECODE, FC_NOP, 8'h00, 1'b0, 4'h0);
      cd_s = 1'b0;
      cyc(UOP_TRANSFER, FC_NOP, ADR_RES_FLAGS, 1'b1, 4'ha);
      cyc(UOP_TRANSFER, FC_NOP, ADR_STAT_FLAGS_HI, 1'b1, 4'h5);
      rd_reg(UOP_GENERAL, ADR_STAT_FLAGS);
      check("stat_wr", rd, 4'h5);
      cyc(UOP_GENERAL, FC_COPY, 8'h00, 1'b0, 4'h0);
      check("res_copy", res, 4'ha);
      rd_reg(UOP_TRANSFER, ADR_STAT_FLAGS_HI);
      check("stat_copy", rd, cexp[k]);
      check("c_skip", {3'h0, skip}, {3'h0, cexp[k][0]});
    end
    cyc(UOP_GENERAL, FC_NOP, ADR_RES_FLAGS, 1'b1, 4'hf);
    check("res_gen_wr", res, 4'ha);
    conclude();
  end
endmodule
